// ==== core/pwm_gen_pkg.sv ====
// Constants shared by the three-channel pulse generator and its leaf modules.
package pwm_gen_pkg;

	// ----------------------------------------------------------------
	// Channel count and field widths
	// ----------------------------------------------------------------
	localparam int NUM_CH = 3;
	localparam int CNT_W = 12;
	localparam int REF_W = 4;
	localparam int ALIGN_W = 2;
	localparam int IDX_W = 8;
	localparam int ADDR_W = 12;

	// ----------------------------------------------------------------
	// Register indices; the byte address of each is four times its index
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] CH1_PERIOD_LO_IDX = 8'h98;
	localparam logic [IDX_W-1:0] CH1_PERIOD_HI_IDX = 8'h99;
	localparam logic [IDX_W-1:0] CH1_DUTY_LO_IDX = 8'h9A;
	localparam logic [IDX_W-1:0] CH1_DUTY_HI_IDX = 8'h9B;
	localparam logic [IDX_W-1:0] CH1_CTRL_IDX = 8'h9C;
	localparam logic [IDX_W-1:0] CH2_PERIOD_LO_IDX = 8'h9D;
	localparam logic [IDX_W-1:0] CH2_PERIOD_HI_IDX = 8'h9E;
	localparam logic [IDX_W-1:0] CH2_DUTY_LO_IDX = 8'h9F;
	localparam logic [IDX_W-1:0] CH2_DUTY_HI_IDX = 8'hA0;
	localparam logic [IDX_W-1:0] CH2_CTRL_IDX = 8'hA1;
	localparam logic [IDX_W-1:0] CH3_PERIOD_LO_IDX = 8'hA2;
	localparam logic [IDX_W-1:0] CH3_PERIOD_HI_IDX = 8'hA3;
	localparam logic [IDX_W-1:0] CH3_DUTY_LO_IDX = 8'hA4;
	localparam logic [IDX_W-1:0] CH3_DUTY_HI_IDX = 8'hA5;
	localparam logic [IDX_W-1:0] CH3_CTRL_IDX = 8'hA6;
	localparam logic [IDX_W-1:0] STATUS_IDX = 8'hA7;
	localparam logic [IDX_W-1:0] FIRST_IDX = CH1_PERIOD_LO_IDX;
	localparam logic [IDX_W-1:0] LAST_IDX = STATUS_IDX;

	localparam logic [IDX_W-1:0] PERIOD_LO_IDX [NUM_CH] =
		'{CH1_PERIOD_LO_IDX, CH2_PERIOD_LO_IDX, CH3_PERIOD_LO_IDX};
	localparam logic [IDX_W-1:0] PERIOD_HI_IDX [NUM_CH] =
		'{CH1_PERIOD_HI_IDX, CH2_PERIOD_HI_IDX, CH3_PERIOD_HI_IDX};
	localparam logic [IDX_W-1:0] DUTY_LO_IDX [NUM_CH] =
		'{CH1_DUTY_LO_IDX, CH2_DUTY_LO_IDX, CH3_DUTY_LO_IDX};
	localparam logic [IDX_W-1:0] DUTY_HI_IDX [NUM_CH] =
		'{CH1_DUTY_HI_IDX, CH2_DUTY_HI_IDX, CH3_DUTY_HI_IDX};
	localparam logic [IDX_W-1:0] CTRL_IDX [NUM_CH] =
		'{CH1_CTRL_IDX, CH2_CTRL_IDX, CH3_CTRL_IDX};

	// ----------------------------------------------------------------
	// Bit positions inside the byte registers
	// ----------------------------------------------------------------
	localparam int HI_NIBBLE_LSB = 0;
	localparam int REF_LSB = 4;
	localparam int ENABLE_BIT = 0;
	localparam int POLARITY_BIT = 1;
	localparam int ALIGN_LSB = 2;
	localparam int CH2_SELECT_BIT = 4;
	localparam int SRGB_ENABLE_BIT = 5;

	// ----------------------------------------------------------------
	// Reset values per channel
	// ----------------------------------------------------------------
	localparam logic [CNT_W-1:0] PERIOD_RST [NUM_CH] = '{12'h100, 12'h200, 12'h300};
	localparam logic [REF_W-1:0] REF_RST [NUM_CH] = '{4'h1, 4'h3, 4'h0};
	localparam logic [CNT_W-1:0] DUTY_RST [NUM_CH] = '{12'h080, 12'h100, 12'h150};
	localparam logic ENABLE_RST = 1'b1;
	localparam logic POLARITY_RST = 1'b0;
	localparam logic [ALIGN_W-1:0] ALIGN_RST [NUM_CH] = '{2'h0, 2'h3, 2'h3};
	localparam logic CH2_SELECT_RST = 1'b0;
	localparam logic SRGB_ENABLE_RST = 1'b0;

	// ----------------------------------------------------------------
	// Alignment field codes and bus answers
	// ----------------------------------------------------------------
	localparam logic [ALIGN_W-1:0] ALIGN_INPUT_VSYNC = 2'h3;
	localparam logic [ALIGN_W-1:0] ALIGN_OUTPUT_VSYNC = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pwm_gen_pkg

// ==== core/vsync_edge_sync.sv ====
// Two-stage synchroniser with a rising-edge pulse for one vertical sync pin.
`timescale 1ns/1ps
`default_nettype none

module vsync_edge_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Pin and pulse
	input wire logic pin_in,
	output logic rise_pulse
);

	logic meta_r;
	logic stable_r;
	logic last_r;

	// The first stage feeds only the second one, so a metastable
	// sample never reaches the edge detector.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			meta_r <= 1'b0;
			stable_r <= 1'b0;
			last_r <= 1'b0;
		end
		else
		begin
			meta_r <= pin_in;
			stable_r <= meta_r;
			last_r <= stable_r;
		end
	end

	assign rise_pulse = stable_r & ~last_r;

endmodule : vsync_edge_sync

`default_nettype wire

// ==== core/pwm_channel.sv ====
// One pulse-width generator: prescaler, period counter and output stage.
`timescale 1ns/1ps
`default_nettype none

module pwm_channel (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Settings
	input wire logic enable,
	input wire logic polarity,
	input wire logic [1:0] align,
	input wire logic [11:0] period,
	input wire logic [3:0] ref_count,
	input wire logic [11:0] duty,
	// Sync events
	input wire logic in_vsync_rise,
	input wire logic out_vsync_rise,
	// Waveform
	output logic pwm_out
);

	logic [pwm_gen_pkg::REF_W-1:0] pre_r;
	logic [pwm_gen_pkg::CNT_W-1:0] count_r;
	logic pwm_r;
	logic tick;
	logic restart;

	assign tick = (pre_r == ref_count);
	assign restart = ((align == pwm_gen_pkg::ALIGN_INPUT_VSYNC) && in_vsync_rise)
		|| ((align == pwm_gen_pkg::ALIGN_OUTPUT_VSYNC) && out_vsync_rise); // RULE_05

	// The reference count stretches each counter step to ref_count + 1
	// system clocks, so slow outputs need no wider period field.
	always_ff @(posedge clk)
	begin
		if (reset || !enable) // RULE_03
		begin
			pre_r <= '0;
			count_r <= '0;
		end
		else if (restart) // RULE_08
		begin
			pre_r <= '0;
			count_r <= '0;
		end
		else if (tick) // RULE_01
		begin
			pre_r <= '0;
			count_r <= (count_r >= period) ? '0 : count_r + 12'h001; // RULE_08
		end
		else
		begin
			pre_r <= pre_r + 4'h1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			pwm_r <= 1'b0;
		else
			pwm_r <= (enable && (count_r < duty)) ^ polarity; // RULE_02 RULE_04
	end

	assign pwm_out = pwm_r;

endmodule : pwm_channel

`default_nettype wire

// ==== core/three_channel_pwm_generator.sv ====
// Three-channel pulse-width generator with an AXI4-Lite register slave.
// Function
// RULE_01: 12-bit period and 4-bit reference count set period.
// RULE_02: 12-bit duty count sets active cycles.
// RULE_03: Per-channel enable bit, resets to one.
// RULE_04: Polarity bit inverts the channel output.
// RULE_05: Align field picks input, output or no vsync.
// RULE_06: Select bit puts inverted channel one on output two.
// RULE_07: Separate SRGB enable bit, resets to zero.
// RULE_08: Counter wraps at period, active below duty.
`timescale 1ns/1ps
`default_nettype none

module three_channel_pwm_generator (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RESET,
	// AXI4-Lite write address
	input wire logic [11:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	// AXI4-Lite write data
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	// AXI4-Lite write response
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// AXI4-Lite read address
	input wire logic [11:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	// AXI4-Lite read data
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// Vertical sync pins
	input wire logic IN_VSYNC,
	input wire logic OUT_VSYNC,
	// Pulse outputs
	output logic PWM_OUT1,
	output logic PWM_OUT2,
	output logic PWM_OUT3,
	output logic SRGB_PWM_ENABLE
);

	localparam int N = pwm_gen_pkg::NUM_CH;
	localparam int IW = pwm_gen_pkg::IDX_W;

	// ----------------------------------------------------------------
	// Settings held per channel
	// ----------------------------------------------------------------
	logic [pwm_gen_pkg::CNT_W-1:0] period_r [N];
	logic [pwm_gen_pkg::REF_W-1:0] ref_r [N];
	logic [pwm_gen_pkg::CNT_W-1:0] duty_r [N];
	logic enable_r [N];
	logic polarity_r [N];
	logic [pwm_gen_pkg::ALIGN_W-1:0] align_r [N];
	logic ch2_select_r;
	logic srgb_enable_r;

	// ----------------------------------------------------------------
	// Bus state
	// ----------------------------------------------------------------
	logic aw_got_r;
	logic [pwm_gen_pkg::ADDR_W-1:0] awaddr_r;
	logic w_got_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic write_go;
	logic [IW-1:0] wr_idx;
	logic wr_hit;
	logic wr_byte;
	logic [7:0] wr_data;
	logic [IW-1:0] rd_idx;
	logic rd_hit;
	logic [7:0] rd_byte;

	// ----------------------------------------------------------------
	// Waveform signals
	// ----------------------------------------------------------------
	logic in_vsync_rise;
	logic out_vsync_rise;
	logic ch_out [N];
	logic out1_r;
	logic out2_r;
	logic out3_r;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic idx_mapped(input logic [pwm_gen_pkg::ADDR_W-1:0] addr);
		logic [IW-1:0] idx;
		idx = addr[IW+1:2];
		idx_mapped = (addr[pwm_gen_pkg::ADDR_W-1:IW+2] == '0)
			&& (idx >= pwm_gen_pkg::FIRST_IDX) && (idx <= pwm_gen_pkg::LAST_IDX);
	endfunction : idx_mapped

	assign wr_idx = awaddr_r[IW+1:2];
	assign wr_hit = idx_mapped(awaddr_r);
	assign write_go = aw_got_r && w_got_r && !bvalid_r;
	// Only the low byte lane carries register data; other lanes are ignored.
	assign wr_byte = write_go && wr_hit && wstrb_r[0];
	assign wr_data = wdata_r[7:0];
	assign rd_idx = ARADDR[IW+1:2];
	assign rd_hit = idx_mapped(ARADDR);

	// ----------------------------------------------------------------
	// Write channels
	// ----------------------------------------------------------------
	// Address and data are caught independently, in either order; the
	// register update and response follow once both are held.
	assign AWREADY = !aw_got_r;
	assign WREADY = !w_got_r;

	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			aw_got_r <= 1'b0;
			awaddr_r <= '0;
		end
		else if (AWVALID && !aw_got_r)
		begin
			aw_got_r <= 1'b1;
			awaddr_r <= AWADDR;
		end
		else if (write_go)
		begin
			aw_got_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			w_got_r <= 1'b0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end
		else if (WVALID && !w_got_r)
		begin
			w_got_r <= 1'b1;
			wdata_r <= WDATA;
			wstrb_r <= WSTRB;
		end
		else if (write_go)
		begin
			w_got_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= pwm_gen_pkg::RESP_OKAY;
		end
		else if (write_go)
		begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_hit ? pwm_gen_pkg::RESP_OKAY : pwm_gen_pkg::RESP_SLVERR;
		end
		else if (BREADY)
		begin
			bvalid_r <= 1'b0;
		end
	end

	assign BVALID = bvalid_r;
	assign BRESP = bresp_r;

	// ----------------------------------------------------------------
	// Channel settings
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS)
	begin
		for (int c = 0; c < N; c++)
		begin
			if (RESET)
			begin
				period_r[c] <= pwm_gen_pkg::PERIOD_RST[c];
				ref_r[c] <= pwm_gen_pkg::REF_RST[c];
				duty_r[c] <= pwm_gen_pkg::DUTY_RST[c];
				enable_r[c] <= pwm_gen_pkg::ENABLE_RST; // RULE_03
				polarity_r[c] <= pwm_gen_pkg::POLARITY_RST;
				align_r[c] <= pwm_gen_pkg::ALIGN_RST[c];
			end
			else if (wr_byte)
			begin
				if (wr_idx == pwm_gen_pkg::PERIOD_LO_IDX[c])
					period_r[c][7:0] <= wr_data; // RULE_01
				if (wr_idx == pwm_gen_pkg::PERIOD_HI_IDX[c])
				begin
					period_r[c][11:8] <= wr_data[pwm_gen_pkg::HI_NIBBLE_LSB +: 4];
					ref_r[c] <= wr_data[pwm_gen_pkg::REF_LSB +: 4]; // RULE_01
				end
				if (wr_idx == pwm_gen_pkg::DUTY_LO_IDX[c])
					duty_r[c][7:0] <= wr_data; // RULE_02
				if (wr_idx == pwm_gen_pkg::DUTY_HI_IDX[c])
					duty_r[c][11:8] <= wr_data[pwm_gen_pkg::HI_NIBBLE_LSB +: 4];
				if (wr_idx == pwm_gen_pkg::CTRL_IDX[c])
				begin
					enable_r[c] <= wr_data[pwm_gen_pkg::ENABLE_BIT]; // RULE_03
					polarity_r[c] <= wr_data[pwm_gen_pkg::POLARITY_BIT]; // RULE_04
					align_r[c] <= wr_data[pwm_gen_pkg::ALIGN_LSB +: 2]; // RULE_05
				end
			end
		end
	end

	// The routing and SRGB bits share the first channel's control byte.
	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			ch2_select_r <= pwm_gen_pkg::CH2_SELECT_RST;
			srgb_enable_r <= pwm_gen_pkg::SRGB_ENABLE_RST; // RULE_07
		end
		else if (wr_byte && (wr_idx == pwm_gen_pkg::CH1_CTRL_IDX))
		begin
			ch2_select_r <= wr_data[pwm_gen_pkg::CH2_SELECT_BIT]; // RULE_06
			srgb_enable_r <= wr_data[pwm_gen_pkg::SRGB_ENABLE_BIT]; // RULE_07
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Unused and reserved bits read as zero.
	always_comb
	begin
		rd_byte = 8'h00;
		for (int c = 0; c < N; c++)
		begin
			if (rd_idx == pwm_gen_pkg::PERIOD_LO_IDX[c])
				rd_byte = period_r[c][7:0];
			if (rd_idx == pwm_gen_pkg::PERIOD_HI_IDX[c])
				rd_byte = {ref_r[c], period_r[c][11:8]};
			if (rd_idx == pwm_gen_pkg::DUTY_LO_IDX[c])
				rd_byte = duty_r[c][7:0];
			if (rd_idx == pwm_gen_pkg::DUTY_HI_IDX[c])
				rd_byte = {4'h0, duty_r[c][11:8]};
			if (rd_idx == pwm_gen_pkg::CTRL_IDX[c])
				rd_byte = {4'h0, align_r[c], polarity_r[c], enable_r[c]};
		end
		if (rd_idx == pwm_gen_pkg::CH1_CTRL_IDX)
		begin
			rd_byte[pwm_gen_pkg::CH2_SELECT_BIT] = ch2_select_r;
			rd_byte[pwm_gen_pkg::SRGB_ENABLE_BIT] = srgb_enable_r;
		end
		if (rd_idx == pwm_gen_pkg::STATUS_IDX)
			rd_byte = {5'h00, PWM_OUT3, PWM_OUT2, PWM_OUT1};
	end

	assign ARREADY = !rvalid_r;

	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= pwm_gen_pkg::RESP_OKAY;
		end
		else if (ARVALID && !rvalid_r)
		begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_hit ? {24'h000000, rd_byte} : 32'h00000000;
			rresp_r <= rd_hit ? pwm_gen_pkg::RESP_OKAY : pwm_gen_pkg::RESP_SLVERR;
		end
		else if (RREADY)
		begin
			rvalid_r <= 1'b0;
		end
	end

	assign RVALID = rvalid_r;
	assign RDATA = rdata_r;
	assign RRESP = rresp_r;

	// ----------------------------------------------------------------
	// Vertical sync pins
	// ----------------------------------------------------------------
	vsync_edge_sync u_in_vsync (
		.clk(CLK_SYS),
		.reset(RESET),
		.pin_in(IN_VSYNC),
		.rise_pulse(in_vsync_rise)
	);

	vsync_edge_sync u_out_vsync (
		.clk(CLK_SYS),
		.reset(RESET),
		.pin_in(OUT_VSYNC),
		.rise_pulse(out_vsync_rise)
	);

	// ----------------------------------------------------------------
	// Generators
	// ----------------------------------------------------------------
	for (genvar g = 0; g < N; g++)
	begin : gen_ch
		pwm_channel u_ch (
			.clk(CLK_SYS),
			.reset(RESET),
			.enable(enable_r[g]),
			.polarity(polarity_r[g]),
			.align(align_r[g]),
			.period(period_r[g]),
			.ref_count(ref_r[g]),
			.duty(duty_r[g]),
			.in_vsync_rise(in_vsync_rise),
			.out_vsync_rise(out_vsync_rise),
			.pwm_out(ch_out[g])
		);
	end

	// ----------------------------------------------------------------
	// Output routing
	// ----------------------------------------------------------------
	// The second pin may carry the complement of the first channel, which
	// gives a matched push-pull pair without a second generator setup.
	// All three pins are retimed here, so the routing mux cannot glitch a
	// pin and the three pins keep the same latency.
	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			out1_r <= 1'b0;
			out2_r <= 1'b0;
			out3_r <= 1'b0;
		end
		else
		begin
			out1_r <= ch_out[0];
			out2_r <= ch2_select_r ? !ch_out[0] : ch_out[1]; // RULE_06
			out3_r <= ch_out[2];
		end
	end

	assign PWM_OUT1 = out1_r;
	assign PWM_OUT2 = out2_r;
	assign PWM_OUT3 = out3_r;
	assign SRGB_PWM_ENABLE = srgb_enable_r; // RULE_07

endmodule : three_channel_pwm_generator

`default_nettype wire

// ==== test/pwm_gen_checker.sv ====
// Port-level assertions for the three-channel pulse generator.
`timescale 1ns/1ps
`default_nettype none

module pwm_gen_checker (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RESET,
	// Write channels
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic [1:0] BRESP,
	input wire logic BVALID,
	input wire logic BREADY,
	// Read channels
	input wire logic [11:0] ARADDR,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic [1:0] RRESP,
	input wire logic RVALID,
	input wire logic RREADY,
	// Outputs
	input wire logic PWM_OUT1,
	input wire logic PWM_OUT2,
	input wire logic PWM_OUT3,
	input wire logic SRGB_PWM_ENABLE
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RESET);

	sequence s_wr_taken;
		AWVALID && AWREADY && WVALID && WREADY && !BVALID;
	endsequence
	sequence s_rd_taken;
		ARVALID && ARREADY;
	endsequence

	property p_wr_resp;
		s_wr_taken |=> !BVALID ##1 BVALID;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
	property p_b_hold;
		BVALID && !BREADY |=> BVALID && $stable(BRESP);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_rd_resp;
		s_rd_taken |=> RVALID && RDATA[31:8] == 24'h0;
	endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
	property p_unmapped;
		s_rd_taken ##0 ARADDR[11:10] != 2'h0 |=> RRESP == 2'h2 && RDATA == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	property p_r_hold;
		RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_ar_block;
		RVALID |-> !ARREADY;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken early");
	property p_rd_done;
		RVALID && RREADY |=> !RVALID;
	endproperty
	a_rd_done: assert property (p_rd_done) else $error("read answer stuck");
	property p_rst_out;
		$past(RESET) |-> !PWM_OUT1 && !PWM_OUT2 && !PWM_OUT3 && !SRGB_PWM_ENABLE;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("outputs after reset");
endmodule : pwm_gen_checker

bind three_channel_pwm_generator pwm_gen_checker pwm_gen_checker_inst (.CLK_SYS, .RESET,
	.AWVALID, .AWREADY, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID,
	.ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .PWM_OUT1, .PWM_OUT2, .PWM_OUT3,
	.SRGB_PWM_ENABLE);
`default_nettype wire

// ==== test/vsync_source.sv ====
// Vertical sync source standing in for the video timing side of the board.
`timescale 1ns/1ps
`default_nettype none

module vsync_source (
	// Clock
	input wire logic clk,
	// Sync pins
	output logic in_vsync,
	output logic out_vsync
);
	initial
	begin
		in_vsync = 1'b0;
		out_vsync = 1'b0;
	end

	// Pin 0 is input sync, pin 1 output sync; four clocks high so the
	// two-stage synchroniser cannot miss the edge.
	task automatic pulse(input logic pin);
		@(posedge clk);
		if (pin)
			out_vsync <= 1'b1;
		else
			in_vsync <= 1'b1;
		repeat (4) @(posedge clk);
		in_vsync <= 1'b0;
		out_vsync <= 1'b0;
	endtask : pulse
endmodule : vsync_source
`default_nettype wire

// ==== test/three_channel_pwm_generator_tb.sv ====
// Self-checking bench for the three-channel pulse generator.
`timescale 1ns/1ps
`default_nettype none

module three_channel_pwm_generator_tb;
	logic CLK_SYS, RESET, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
	logic ARVALID, ARREADY, RVALID, RREADY, IN_VSYNC, OUT_VSYNC;
	logic PWM_OUT1, PWM_OUT2, PWM_OUT3, SRGB_PWM_ENABLE;
	logic [11:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA;
	logic [3:0] WSTRB;
	logic [1:0] BRESP, RRESP;
	int fails, total_checks;

	three_channel_pwm_generator three_channel_pwm_generator_inst (.CLK_SYS, .RESET,
		.AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID,
		.BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
		.IN_VSYNC, .OUT_VSYNC, .PWM_OUT1, .PWM_OUT2, .PWM_OUT3, .SRGB_PWM_ENABLE);
	vsync_source vsync_source_inst (.clk(CLK_SYS), .in_vsync(IN_VSYNC), .out_vsync(OUT_VSYNC));

	initial
	begin
		CLK_SYS = 1'b0;
		forever #4 CLK_SYS = ~CLK_SYS;
	end

	// ----------------------------------------------------------------
	// Reporting and bus access
	// ----------------------------------------------------------------
	task automatic test_done;
		if (fails == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic hang;
		fails++;
		$display("CHECK FAILED at %0t: wait ran out", $time);
		test_done();
	endtask : hang

	function automatic logic [11:0] ba(input logic [7:0] i);
		return {2'h0, i, 2'h0};
	endfunction : ba

	// Each ready is raised with its request and held until the answer is seen.
	task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
		int n;
		@(posedge CLK_SYS);
		AWADDR <= a;
		WDATA <= {24'h0, d};
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge CLK_SYS);
			if (BVALID && BREADY)
				break;
			if (AWREADY)
				AWVALID <= 1'b0;
			if (WREADY)
				WVALID <= 1'b0;
		end
		r = BRESP;
		BREADY <= 1'b0;
		if (n == 50)
			hang();
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge CLK_SYS);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge CLK_SYS);
			if (RVALID && RREADY)
				break;
			if (ARREADY)
				ARVALID <= 1'b0;
		end
		d = RDATA;
		r = RRESP;
		RREADY <= 1'b0;
		if (n == 50)
			hang();
	endtask : rd

	task automatic poke(input logic [7:0] i, input logic [7:0] d);
		logic [1:0] r;
		wr(ba(i), d, r);
	endtask : poke

	task automatic lvl(input logic v);
		int n;
		for (n = 0; n < 300 && PWM_OUT3 !== v; n++)
			@(negedge CLK_SYS);
		if (n == 300)
			hang();
	endtask : lvl

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_values;
		logic [11:0] p, u;
		logic [7:0] ex [5];
		logic [31:0] d;
		logic [1:0] r;
		for (int c = 0; c < 3; c++)
		begin
			p = pwm_gen_pkg::PERIOD_RST[c];
			u = pwm_gen_pkg::DUTY_RST[c];
			ex = '{p[7:0], {pwm_gen_pkg::REF_RST[c], p[11:8]}, u[7:0], {4'h0, u[11:8]},
				{4'h0, pwm_gen_pkg::ALIGN_RST[c], 2'h1}};
			for (int k = 0; k < 5; k++)
			begin
				rd(ba(pwm_gen_pkg::PERIOD_LO_IDX[c] + 8'(k)), d, r);
				chk(d, {24'h0, ex[k]});
			end
		end
	endtask : t_reset_values

	task automatic t_bus;
		logic [31:0] d;
		logic [1:0] r;
		poke(pwm_gen_pkg::CH2_CTRL_IDX, 8'h3F);
		rd(ba(pwm_gen_pkg::CH2_CTRL_IDX), d, r);
		chk(d, 32'h0000_000F);
		wr(12'h400, 8'h55, r);
		chk(r, pwm_gen_pkg::RESP_SLVERR);
		rd(12'h400, d, r);
		chk({r, d[29:0]}, {pwm_gen_pkg::RESP_SLVERR, 30'h0});
	endtask : t_bus

	// Period of four steps; the window is a whole number of periods.
	task automatic t_wave;
		logic [7:0] hi [5] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
		logic [7:0] du [5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h05};
		logic [7:0] ct [5] = '{8'h01, 8'h03, 8'h00, 8'h01, 8'h01};
		int ex [5] = '{4, 12, 0, 4, 16};
		int h;
		poke(pwm_gen_pkg::CH3_CTRL_IDX, 8'h00);
		poke(pwm_gen_pkg::CH3_PERIOD_LO_IDX, 8'h03);
		poke(pwm_gen_pkg::CH3_DUTY_HI_IDX, 8'h00);
		for (int i = 0; i < 5; i++)
		begin
			poke(pwm_gen_pkg::CH3_CTRL_IDX, 8'h00);
			poke(pwm_gen_pkg::CH3_PERIOD_HI_IDX, hi[i]);
			poke(pwm_gen_pkg::CH3_DUTY_LO_IDX, du[i]);
			poke(pwm_gen_pkg::CH3_CTRL_IDX, ct[i]);
			repeat (4) @(negedge CLK_SYS);
			h = 0;
			repeat (16) @(negedge CLK_SYS) if (PWM_OUT3 === 1'b1) h++;
			chk(h, ex[i]);
		end
	endtask : t_wave

	task automatic t_select;
		int e;
		poke(pwm_gen_pkg::CH1_CTRL_IDX, 8'h31);
		@(negedge CLK_SYS);
		chk(SRGB_PWM_ENABLE, 1'b1);
		e = 0;
		repeat (24) @(negedge CLK_SYS) if (PWM_OUT2 !== ~PWM_OUT1) e++;
		chk(e, 0);
		poke(pwm_gen_pkg::CH1_CTRL_IDX, 8'h02);
		@(negedge CLK_SYS);
		chk(SRGB_PWM_ENABLE, 1'b0);
		// Both channels idle at their inverted level: a stuck routing mux shows a zero.
		poke(pwm_gen_pkg::CH2_CTRL_IDX, 8'h02);
		repeat (3) @(negedge CLK_SYS);
		chk({PWM_OUT2, PWM_OUT1}, 2'h3);
	endtask : t_select

	// Sync arrives deep in the inactive part; only a restart brings the output up.
	task automatic t_align;
		logic [1:0] al;
		logic got, ex;
		poke(pwm_gen_pkg::CH3_CTRL_IDX, 8'h00);
		poke(pwm_gen_pkg::CH3_PERIOD_LO_IDX, 8'hFF);
		poke(pwm_gen_pkg::CH3_PERIOD_HI_IDX, 8'h00);
		poke(pwm_gen_pkg::CH3_DUTY_LO_IDX, 8'h10);
		for (int a = 0; a < 4; a++)
			for (int p = 0; p < 2; p++)
			begin
				al = a[1:0];
				poke(pwm_gen_pkg::CH3_CTRL_IDX, {4'h0, al, 2'h1});
				lvl(1'b1);
				lvl(1'b0);
				vsync_source_inst.pulse(p[0]);
				got = 1'b0;
				repeat (12) @(negedge CLK_SYS) if (PWM_OUT3 === 1'b1) got = 1'b1;
				ex = (al == 2'h3 && p == 0) || (al == 2'h2 && p == 1);
				chk(got, ex);
			end
	endtask : t_align

	initial
	begin
		fails = 0;
		total_checks = 0;
		RESET = 1'b1;
		AWADDR = 12'h000;
		ARADDR = 12'h000;
		WDATA = 32'h0;
		WSTRB = 4'hF;
		AWVALID = 1'b0;
		WVALID = 1'b0;
		BREADY = 1'b0;
		ARVALID = 1'b0;
		RREADY = 1'b0;
		repeat (10) @(posedge CLK_SYS);
		RESET <= 1'b0;
		t_reset_values();
		t_bus();
		t_wave();
		t_select();
		t_align();
		test_done();
	end
endmodule : three_channel_pwm_generator_tb
`default_nettype wire
